// file: power_mode_and_fast_wakeup_ctrl.sv
// Power-mode controller with halt decoding, wake latency and APB registers.
// Notes on behaviour
// [RULE1] Software sets or clears fast wake bit.
// [RULE2] Fast wake only from watchdog sleep, idle_no_sysclk_state.
// [RULE3] Deep sleep wake ignores fast bit.
// [RULE4] Crystal fast wake: subclock until 128 cycles.
// [RULE5] Internal oscillators wake in 16 or 2.
// [RULE6] Watchdog off: no fast wake from deep.
// [RULE7] Halt picks idle/sleep; select bits pick speed.
// [RULE8] Slow clock selected stops fast oscillator.
// [RULE9] Software enters slow mode via divider code.
// [RULE10] Slow switch completes after slow ready.
// [RULE11] Software returns to fast mode, checks ready.
// [RULE12] Halt, idle off, watchdog/detector off: deep sleep.
// [RULE13] Deep sleep clears and stops watchdog.
// [RULE14] Halt, idle off, watchdog/detector on: watchdog sleep.
// [RULE15] Halt, idle on, keep off: idle_no_sysclk_state.
// [RULE16] Low-power states stop execution, keep state.
// [RULE17] Entry sets power-down, clears timeout flag.
// [RULE18] Watchdog cleared, resumes in watchdog_sleep_state/idle_no_sysclk_state.
// [RULE19] Slow ready low in deep, high after 2.
// [RULE20] Halt, idle and keep on: full idle.
// [RULE21] Wake input starts matching stabilisation count.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module power_mode_and_fast_wakeup_ctrl
	import power_mode_pkg::*;
#(
	parameter int XTAL_DIV = CLK_HZ / XTAL_HZ,
	parameter int FAST_DIV = CLK_HZ / FAST_HZ,
	parameter int SLOW_DIV = CLK_HZ / SLOW_HZ
)(
	input  wire logic        clock_in,
	input  wire logic        nrst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        halt_in,
	input  wire logic        wake_in,
	input  wire logic        wdt_enable_in,
	input  wire logic        lvd_enable_in,
	input  wire logic        wdt_timeout_in,
	input  wire logic        wdt_clear_cmd_in,
	output logic             cpu_run_out,
	output logic             sysclk_enable_out,
	output logic             timebase_enable_out,
	output logic             subclock_enable_out,
	output logic             high_osc_enable_out,
	output logic             sysclk_on_low_out,
	output logic             wdt_clear_out,
	output logic             wdt_run_out
);

	////////////////////////////////////////////////////////////////////////
	// State record; every flip-flop of the block except the reset synchroniser lives here.
	typedef struct packed {
		pm_state_t               state;          // Operating state.
		logic                    hsel;           // Clock select bit.
		logic                    idle_en;        // Idle on halt.
		logic                    keep_sys;       // Keep clock in idle.
		logic                    fast_en;        // Fast wake enable.
		logic [2:0]              div_sel;        // Slow divider field.
		osc_t                    osc_type;       // System oscillator type.
		logic                    power_down_flag;            // Power-down flag.
		logic                    tof;            // Watchdog timeout flag.
		logic                    hi_rdy;         // Fast oscillator ready.
		logic                    lo_rdy;         // Slow oscillator ready.
		logic [7:0]              hi_cnt;         // Fast stabilisation count.
		logic [1:0]              lo_cnt;         // Slow stabilisation count.
		logic [1:0]              wk_cnt;         // Short wake count.
		logic [2:0][DIV_W-1:0]   div_cnt;        // Oscillator tick dividers.
		logic [31:0]             prdata;
		logic                    pready;
		logic                    pslverr;
		logic                    cpu_run;
		logic                    sysclk_en;
		logic                    tb_en;
		logic                    sub_en;
		logic                    hosc_en;
		logic                    on_low;
		logic                    wdt_clr;
		logic                    wdt_run;
	} st_t;

	st_t  s;        // Registered state.
	st_t  next_s;   // Value for the next edge.
	logic rst_meta; // Reset synchroniser, first stage.
	logic rst_n;    // Synchronised reset used by the block.

	////////////////////////////////////////////////////////////////////////
	// Divider limit per oscillator, used by the tick generator.
	function automatic logic [DIV_W-1:0] div_lim(input int idx);
		if (idx == 0)
			return DIV_W'(XTAL_DIV - 1);
		else if (idx == 1)
			return DIV_W'(FAST_DIV - 1);
		else
			return DIV_W'(SLOW_DIV - 1);
	endfunction

	// Stabilisation length of each system oscillator type.
	function automatic logic [7:0] wake_target(input osc_t t);
		unique case (t)
			OSC_XTAL: return XTAL_WAKE_CYC;
			OSC_FAST: return FAST_WAKE_CYC;
			OSC_SLOW: return SLOW_WAKE_CYC;
			default:  return XTAL_WAKE_CYC;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops; assertion is immediate.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic of the whole controller.
	logic       slow_req;  // Divider code selects the slow oscillator.
	logic       hi_on;     // Fast oscillator is powered.
	logic       lo_on;     // Slow oscillator is powered.
	logic [2:0] osc_on;    // Per-oscillator run enables.
	logic [2:0] tick;      // One-cycle oscillator ticks.
	logic       hi_tick;   // Tick of the selected system oscillator.
	logic       sys_tick;  // Tick of the clock the core runs on.
	logic       entering;  // A halt is taken this cycle.
	logic       access;    // APB access phase completes this edge.
	logic       wr_mode;   // Write to the mode register.
	logic       wr_stat;   // Write to the status register.
	logic       mapped;    // Address hits a register.
	logic [31:0] rd_mux;   // Read data of the addressed register.

	always_comb
	begin
		next_s   = s;
		tick     = 3'h0;
		entering = 1'b0;
		rd_mux   = 32'h0;
		// [RULE9] [RULE11] Speed follows only the select bit and divider.
		slow_req = !s.hsel && (s.div_sel <= SLOW_DIV_MAX);
		// [RULE6] Slow oscillator stops only in deep sleep.
		lo_on    = (s.state != ST_DEEP);
		// [RULE8] Fast oscillator stops once slow mode has taken over.
		hi_on    = (s.state inside {ST_RUN, ST_FULL_IDLE_STATE, ST_WAIT, ST_FSYNC,
			ST_SUBRUN, ST_SHORT}) && (!slow_req || !s.lo_rdy);
		osc_on   = {lo_on, hi_on && (s.osc_type == OSC_FAST),
			hi_on && (s.osc_type == OSC_XTAL)};
		// Tick dividers; a stopped oscillator also clears its divider.
		for (int i = 0; i < 3; i++)
		begin
			if (!osc_on[i])
				next_s.div_cnt[i] = '0;
			else if (s.div_cnt[i] == div_lim(i))
			begin
				next_s.div_cnt[i] = '0;
				tick[i]           = 1'b1;
			end
			else
				next_s.div_cnt[i] = s.div_cnt[i] + 1'b1;
		end
		unique case (s.osc_type)
			OSC_XTAL: hi_tick = tick[0];
			OSC_FAST: hi_tick = tick[1];
			OSC_SLOW: hi_tick = tick[2];
			default:  hi_tick = 1'b0;
		endcase
		sys_tick = slow_req ? tick[2] : hi_tick;

		// [RULE5] Fast ready after the latency of the oscillator type.
		if (!hi_on)
		begin
			next_s.hi_rdy = 1'b0;
			next_s.hi_cnt = 8'h0;
		end
		else if (!s.hi_rdy && hi_tick)
		begin
			if (s.hi_cnt == wake_target(s.osc_type) - 8'h1)
				next_s.hi_rdy = 1'b1;
			else
				next_s.hi_cnt = s.hi_cnt + 8'h1;
		end

		// [RULE19] Slow ready is low in deep sleep, high two ticks later.
		if (!lo_on)
		begin
			next_s.lo_rdy = 1'b0;
			next_s.lo_cnt = 2'h0;
		end
		else if (!s.lo_rdy && tick[2])
		begin
			if (s.lo_cnt == SLOW_WAKE_CYC[1:0] - 2'h1)
				next_s.lo_rdy = 1'b1;
			else
				next_s.lo_cnt = s.lo_cnt + 2'h1;
		end

		// Operating state machine.
		unique case (s.state)
			ST_RUN:
			begin
				// [RULE7] Halt decodes into one of four low-power states.
				if (halt_in)
				begin
					entering = 1'b1;
					if (!s.idle_en && !(wdt_enable_in || lvd_enable_in))
						next_s.state = ST_DEEP;     // [RULE12]
					else if (!s.idle_en)
						next_s.state = ST_WSLEEP;   // [RULE14]
					else if (!s.keep_sys)
						next_s.state = ST_IDLE_NO_SYSCLK_STATE;    // [RULE15]
					else
						next_s.state = ST_FULL_IDLE_STATE;    // [RULE20]
				end
			end
			ST_DEEP, ST_WSLEEP, ST_IDLE_NO_SYSCLK_STATE:
			begin
				// [RULE21] Wake starts the count that fits the setup.
				if (wake_in)
				begin
					next_s.wk_cnt = 2'h0;
					// [RULE2] [RULE3] Subclock path only where it runs.
					if (s.state != ST_DEEP && s.fast_en && s.osc_type == OSC_XTAL)
						next_s.state = ST_FSYNC;
					else
						next_s.state = ST_WAIT;
				end
			end
			ST_FULL_IDLE_STATE:
			begin
				// Clocks kept running, so only a short resync is needed.
				if (wake_in)
				begin
					next_s.wk_cnt = 2'h0;
					next_s.state  = ST_SHORT;
				end
			end
			ST_FSYNC:
			begin
				// [RULE4] Two subclock cycles before the core restarts.
				if (tick[2])
				begin
					if (s.wk_cnt == SHORT_WAKE_CYC - 2'h1)
						next_s.state = ST_SUBRUN;
					else
						next_s.wk_cnt = s.wk_cnt + 2'h1;
				end
			end
			ST_SUBRUN:
			begin
				// [RULE4] Core runs on the subclock until the crystal is ready.
				if (s.hi_rdy)
					next_s.state = ST_RUN;
			end
			ST_WAIT:
			begin
				// [RULE3] Full start-up wait of the oscillator in use.
				if (slow_req ? s.lo_rdy : s.hi_rdy)
					next_s.state = ST_RUN;
			end
			ST_SHORT:
			begin
				if (sys_tick)
				begin
					if (s.wk_cnt == SHORT_WAKE_CYC - 2'h1)
						next_s.state = ST_RUN;
					else
						next_s.wk_cnt = s.wk_cnt + 2'h1;
				end
			end
			default: next_s.state = ST_RUN;
		endcase

		// APB slave with one wait state; the edge with pready high commits.
		access = psel_in && penable_in && s.pready;
		mapped = (paddr_in == MODE_ADDR) || (paddr_in == STAT_ADDR) ||
			(paddr_in == STATE_ADDR);
		wr_mode = access && pwrite_in && (paddr_in == MODE_ADDR);
		wr_stat = access && pwrite_in && (paddr_in == STAT_ADDR);
		rd_mux[HSEL_BIT] = (paddr_in == MODE_ADDR) && s.hsel;
		if (paddr_in == MODE_ADDR)
		begin
			rd_mux[IDLE_BIT]             = s.idle_en;
			rd_mux[HRDY_BIT]             = s.hi_rdy;
			rd_mux[LRDY_BIT]             = s.lo_rdy;
			rd_mux[FAST_BIT]             = s.fast_en;
			rd_mux[DIV_LSB +: 3]         = s.div_sel;
			rd_mux[OSC_LSB +: 2]         = s.osc_type;
			rd_mux[KEEP_BIT]             = s.keep_sys;
		end
		else if (paddr_in == STAT_ADDR)
		begin
			rd_mux[PDF_BIT] = s.power_down_flag;
			rd_mux[TO_BIT]  = s.tof;
		end
		else if (paddr_in == STATE_ADDR)
			rd_mux[3:0] = s.state;
		next_s.pready  = psel_in && penable_in && !s.pready;
		next_s.pslverr = psel_in && penable_in && !s.pready && !mapped;
		if (psel_in && penable_in && !s.pready)
			next_s.prdata = rd_mux;

		// [RULE1] Control fields written by software; ready bits read only.
		if (wr_mode)
		begin
			next_s.hsel     = pwdata_in[HSEL_BIT];
			next_s.idle_en  = pwdata_in[IDLE_BIT];
			next_s.fast_en  = pwdata_in[FAST_BIT];
			next_s.div_sel  = pwdata_in[DIV_LSB +: 3];
			next_s.osc_type = osc_t'(pwdata_in[OSC_LSB +: 2]);
			next_s.keep_sys = pwdata_in[KEEP_BIT];
		end

		// [RULE17] Flags on entry; a setting event beats any clear.
		if (entering || wdt_timeout_in)
			next_s.power_down_flag = s.power_down_flag | entering;
		if ((wr_stat && pwdata_in[PDF_BIT]) || wdt_clear_cmd_in)
			next_s.power_down_flag = entering;
		if (entering || (wr_stat && pwdata_in[TO_BIT]))
			next_s.tof = 1'b0;
		if (wdt_timeout_in)
			next_s.tof = 1'b1;

		// Registered outputs follow the next state, except hosc_en and the slow-mode term of on_low, which register hi_on, slow_req and lo_rdy of the present state.
		// [RULE16] Execution stops in every low-power and wait state.
		next_s.cpu_run   = next_s.state inside {ST_RUN, ST_SUBRUN};
		next_s.sysclk_en = next_s.state inside {ST_RUN, ST_FULL_IDLE_STATE, ST_SUBRUN};
		next_s.tb_en     = next_s.state inside {ST_RUN, ST_IDLE_NO_SYSCLK_STATE, ST_FULL_IDLE_STATE,
			ST_SUBRUN};
		next_s.sub_en    = (next_s.state != ST_DEEP);
		next_s.hosc_en   = hi_on;
		// [RULE10] Core moves to the slow clock only once it is stable.
		next_s.on_low    = (next_s.state == ST_SUBRUN) || (slow_req && s.lo_rdy);
		// [RULE13] [RULE18] Watchdog cleared on entry, runs unless deep.
		next_s.wdt_clr   = entering;
		next_s.wdt_run   = wdt_enable_in && (next_s.state != ST_DEEP);
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s         <= '0;
			s.hsel    <= RST_HSEL;
			s.div_sel <= RST_DIV;
			s.fast_en <= RST_FAST;
		end
		else
			s <= next_s;
	end

	assign prdata_out          = s.prdata;
	assign pready_out          = s.pready;
	assign pslverr_out         = s.pslverr;
	assign cpu_run_out         = s.cpu_run;
	assign sysclk_enable_out   = s.sysclk_en;
	assign timebase_enable_out = s.tb_en;
	assign subclock_enable_out = s.sub_en;
	assign high_osc_enable_out = s.hosc_en;
	assign sysclk_on_low_out   = s.on_low;
	assign wdt_clear_out       = s.wdt_clr;
	assign wdt_run_out         = s.wdt_run;

	////////////////////////////////////////////////////////////////////////
	// Assertions and covers.
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n);

	property p_deep;
		s.state == ST_RUN && halt_in && !s.idle_en && !wdt_enable_in && !lvd_enable_in
			|=> s.state == ST_DEEP && !wdt_run_out;
	endproperty
	a_deep: assert property (p_deep) else $error("halt missed deep sleep"); // [RULE12]

	property p_wsleep;
		s.state == ST_RUN && halt_in && !s.idle_en && wdt_enable_in
			|=> s.state == ST_WSLEEP && wdt_run_out && subclock_enable_out;
	endproperty
	a_wsleep: assert property (p_wsleep) else $error("halt missed wdt sleep"); // [RULE14]

	property p_idle_no_sysclk_state;
		s.state == ST_RUN && halt_in && s.idle_en && !s.keep_sys
			|=> s.state == ST_IDLE_NO_SYSCLK_STATE && timebase_enable_out && !sysclk_enable_out;
	endproperty
	a_idle_no_sysclk_state: assert property (p_idle_no_sysclk_state) else $error("halt missed idle_no_sysclk_state"); // [RULE15]

	property p_full_idle_state;
		s.state == ST_RUN && halt_in && s.idle_en && s.keep_sys
			|=> s.state == ST_FULL_IDLE_STATE && sysclk_enable_out && !cpu_run_out;
	endproperty
	a_full_idle_state: assert property (p_full_idle_state) else $error("halt missed full idle"); // [RULE20]

	property p_flags;
		s.state == ST_RUN && halt_in && !wdt_timeout_in
			|=> s.power_down_flag && !s.tof && wdt_clear_out ##1 !wdt_clear_out;
	endproperty
	a_flags: assert property (p_flags) else $error("entry flags wrong"); // [RULE17]

	property p_deep_wake;
		s.state == ST_DEEP && wake_in |=> s.state == ST_WAIT;
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("fast wake from deep"); // [RULE3]

	property p_fast;
		s.state inside {ST_WSLEEP, ST_IDLE_NO_SYSCLK_STATE} && wake_in && s.fast_en &&
			s.osc_type == OSC_XTAL |=> s.state == ST_FSYNC;
	endproperty
	a_fast: assert property (p_fast) else $error("fast wake not taken"); // [RULE2]

	// The outputs other than hosc_en and the slow-mode term of on_low are registered from the next state, so they match the state they stand with.
	property p_subrun;
		s.state == ST_SUBRUN |-> sysclk_on_low_out && cpu_run_out;
	endproperty
	a_subrun: assert property (p_subrun) else $error("subclock run wrong"); // [RULE4]

	property p_sub_exit;
		s.state == ST_SUBRUN && s.hi_rdy |=> s.state == ST_RUN;
	endproperty
	a_sub_exit: assert property (p_sub_exit) else $error("crystal switch missed"); // [RULE4]

	// Slow ready is cleared from the present state, so it falls one edge after deep sleep is entered and is looked at one edge on.
	property p_lo_deep;
		s.state == ST_DEEP |-> !subclock_enable_out ##1 !s.lo_rdy;
	endproperty
	a_lo_deep: assert property (p_lo_deep) else $error("slow ready in deep"); // [RULE19]

	property p_halted;
		s.state inside {ST_DEEP, ST_WSLEEP, ST_IDLE_NO_SYSCLK_STATE, ST_FULL_IDLE_STATE, ST_WAIT}
			|-> !cpu_run_out;
	endproperty
	a_halted: assert property (p_halted) else $error("core ran while halted"); // [RULE16]

	property p_hs_off;
		s.state == ST_RUN && slow_req && s.lo_rdy |=> !high_osc_enable_out;
	endproperty
	a_hs_off: assert property (p_hs_off) else $error("fast osc left on"); // [RULE8]

	c_fast_wake: cover property (s.state == ST_SUBRUN ##1 s.state == ST_RUN);
	c_deep_wake: cover property (s.state == ST_WAIT ##1 s.state == ST_RUN);
	c_full_idle_state_wake: cover property (s.state == ST_SHORT ##1 s.state == ST_RUN);
	c_slow_mode: cover property (sysclk_on_low_out && s.state == ST_RUN);

endmodule

// file: power_mode_pkg.sv
// Shared constants and types of the power-mode and wake-up controller.
package power_mode_pkg;

	// Clock rates; the dividers derive oscillator ticks from them.
	localparam int CLK_HZ        = 200_000_000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int XTAL_HZ       = 8_000_000;
	localparam int FAST_HZ       = 8_000_000;
	localparam int SLOW_HZ       = 32_000;
	localparam int DIV_W         = 13;

	// Register byte addresses.
	localparam logic [11:0] MODE_ADDR  = 12'h000;
	localparam logic [11:0] STAT_ADDR  = 12'h004;
	localparam logic [11:0] STATE_ADDR = 12'h008;

	// Field positions in the system mode register.
	localparam int HSEL_BIT = 0;
	localparam int IDLE_BIT = 1;
	localparam int HRDY_BIT = 2;
	localparam int LRDY_BIT = 3;
	localparam int FAST_BIT = 4;
	localparam int DIV_LSB  = 5;
	localparam int OSC_LSB  = 8;
	localparam int KEEP_BIT = 10;

	// Field positions in the status register.
	localparam int PDF_BIT = 0;
	localparam int TO_BIT  = 1;

	// Reset values of the control fields.
	localparam logic       RST_HSEL = 1'b1;
	localparam logic [2:0] RST_DIV  = 3'h0;
	localparam logic       RST_FAST = 1'b0;

	// Wake-up latencies in oscillator cycles.
	localparam logic [7:0] XTAL_WAKE_CYC  = 8'h80;
	localparam logic [7:0] FAST_WAKE_CYC  = 8'h10;
	localparam logic [7:0] SLOW_WAKE_CYC  = 8'h02;
	localparam logic [1:0] SHORT_WAKE_CYC = 2'h2;

	// Highest divider code that still selects the slow oscillator.
	localparam logic [2:0] SLOW_DIV_MAX = 3'h1;

	// System oscillator types; code 3 is unused.
	typedef enum logic [1:0] {OSC_XTAL, OSC_FAST, OSC_SLOW} osc_t;

	// Operating states of the controller.
	typedef enum logic [3:0] {
		ST_RUN, ST_DEEP, ST_WSLEEP, ST_IDLE_NO_SYSCLK_STATE, ST_FULL_IDLE_STATE,
		ST_WAIT, ST_FSYNC, ST_SUBRUN, ST_SHORT
	} pm_state_t;

endpackage

// file: power_mode_and_fast_wakeup_ctrl_tb.sv
// Self-checking testbench of the power-mode and wake-up controller.
`timescale 1ns/1ps

module power_mode_and_fast_wakeup_ctrl_tb
	import power_mode_pkg::*;
();

	////////////////////////////////////////////////////////////////////////////////
	// Short oscillator dividers keep the 128-tick crystal count near 256 clocks.
	localparam int XD = 2;
	localparam int FD = 2;
	localparam int SD = 4;

	logic        clock_in;    // Bench clock.
	logic        nrst_in;     // Active-low reset.
	logic        psel;        // APB select.
	logic        penable;     // APB enable.
	logic        pwrite;      // APB direction.
	logic [11:0] paddr;       // APB address.
	logic [31:0] pwdata;      // APB write data.
	logic [31:0] prdata;      // APB read data.
	logic        pready;      // APB ready.
	logic        pslverr;     // APB error.
	logic        halt;        // Halt instruction pulse.
	logic        wake;        // Wake request.
	logic        wdt_en;      // Watchdog on.
	logic        lvd_en;      // Voltage detector on.
	logic        wdt_to;      // Timeout pulse.
	logic        wdt_clr_cmd; // Clear-watchdog instruction pulse.
	logic        cpu_run;     // Core executing.
	logic        sys_en;      // System clock gate.
	logic        tb_en;       // Time-base clock gate.
	logic        sub_en;      // Subclock gate.
	logic        hosc_en;     // Fast oscillator power.
	logic        on_low;      // Core on the subclock.
	logic        wdt_clr;     // Watchdog clear pulse.
	logic        wdt_run;     // Watchdog counting.
	int          miscompares; // Mismatches seen.
	int          checks;      // Comparisons made.

	power_mode_and_fast_wakeup_ctrl #(.XTAL_DIV(XD), .FAST_DIV(FD), .SLOW_DIV(SD))
		u_power_mode_and_fast_wakeup_ctrl (
		.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .halt_in(halt), .wake_in(wake),
		.wdt_enable_in(wdt_en), .lvd_enable_in(lvd_en), .wdt_timeout_in(wdt_to),
		.wdt_clear_cmd_in(wdt_clr_cmd), .cpu_run_out(cpu_run), .sysclk_enable_out(sys_en),
		.timebase_enable_out(tb_en), .subclock_enable_out(sub_en),
		.high_osc_enable_out(hosc_en), .sysclk_on_low_out(on_low),
		.wdt_clear_out(wdt_clr), .wdt_run_out(wdt_run));

	// Free-running clock at the design rate.
	initial
	begin
		clock_in = 1'b0;
		forever #(CLK_PERIOD_NS / 2.0) clock_in = ~clock_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Compares a design value; case inequality lets no unknown pass.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Compares a measured latency in clocks against a window.
	task automatic chk_rng(input string what, input int lo, input int hi, input int n);
		checks++;
		if (n < lo || n > hi)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %0d to %0d seen %0d", what, lo, hi, n);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clock_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		// Read right after an edge, pready and prdata still hold what that edge sampled.
		@(posedge clock_in);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				miscompares++;
				$display("CHECK FAILED pready expected 1 seen timeout");
				give_verdict();
			end
			@(posedge clock_in);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk("write error", 32'h0, {31'h0, e});
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk("read error", 32'h0, {31'h0, e});
	endtask

	// Builds a system mode register word.
	function automatic logic [31:0] mw(logic h, logic i, logic f, logic [2:0] dv,
		logic [1:0] o, logic k);
		mw = 32'h0;
		mw[HSEL_BIT] = h;
		mw[IDLE_BIT] = i;
		mw[FAST_BIT] = f;
		mw[DIV_LSB+:3] = dv;
		mw[OSC_LSB+:2] = o;
		mw[KEEP_BIT] = k;
	endfunction

	// Counts clocks until an output reaches a level: 0 core, 1 on-low, 2 fast osc.
	task automatic wait_sig(input int which, input logic v, input int lim, output int n);
		logic s;
		n = 0;
		forever
		begin
			@(negedge clock_in);
			case (which)
				0: s = cpu_run;
				1: s = on_low;
				default: s = hosc_en;
			endcase
			if (s === v)
				break;
			n++;
			if (n > lim)
			begin
				miscompares++;
				$display("CHECK FAILED wait %0d expected %b seen timeout", which, v);
				give_verdict();
			end
		end
	endtask

	// Polls the fast ready flag; each read costs four clocks.
	task automatic wait_hrdy;
		logic [31:0] r;
		int          n;
		n = 0;
		rd(MODE_ADDR, r);
		while (r[HRDY_BIT] !== 1'b1)
		begin
			n++;
			if (n > 200)
			begin
				miscompares++;
				$display("CHECK FAILED fast ready expected 1 seen timeout");
				give_verdict();
			end
			rd(MODE_ADDR, r);
		end
	endtask

	// A one-cycle pulse on a bench input: 0 halt, 1 wake, 2 timeout, 3 clear command.
	task automatic pulse(input int which);
		@(posedge clock_in);
		case (which)
			0: halt <= 1'b1;
			1: wake <= 1'b1;
			2: wdt_to <= 1'b1;
			default: wdt_clr_cmd <= 1'b1;
		endcase
		@(posedge clock_in);
		{halt, wake, wdt_to, wdt_clr_cmd} <= 4'h0;
		@(negedge clock_in);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, an unmapped address and the write-one-to-clear timeout flag.
	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		wait_hrdy();
		rd(MODE_ADDR, r);
		r[LRDY_BIT] = 1'b0;
		chk("mode reset", mw(RST_HSEL, 0, RST_FAST, RST_DIV, OSC_XTAL, 0) | 32'h4, r);
		rd(STATE_ADDR, r);
		chk("state reset", 32'(ST_RUN), r);
		apb(1'b0, 12'h00c, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		pulse(2);
		rd(STAT_ADDR, r);
		chk("timeout set", 32'h2, r);
		wr(STAT_ADDR, 32'h2);
		rd(STAT_ADDR, r);
		chk("timeout cleared", 32'h0, r);
	endtask

	// Each halt decoding, its clock gates, flags and watchdog handling, then wake.
	task automatic t_halt_modes;
		logic [3:0]  ci [5] = '{4'b0000, 4'b0010, 4'b0001, 4'b1010, 4'b1110};
		pm_state_t   cs [5] = '{ST_DEEP, ST_WSLEEP, ST_WSLEEP, ST_IDLE_NO_SYSCLK_STATE, ST_FULL_IDLE_STATE};
		logic [3:0]  co [5] = '{4'b0000, 4'b0011, 4'b0010, 4'b0111, 4'b1111};
		logic [31:0] r;
		int          n;
		for (int i = 0; i < 5; i++)
		begin
			wdt_en <= ci[i][1];
			lvd_en <= ci[i][0];
			wr(MODE_ADDR, mw(1, ci[i][3], 0, 3'h0, OSC_XTAL, ci[i][2]));
			pulse(2);
			pulse(0);
			chk("core halted", 32'h0, cpu_run);
			chk("watchdog clear", 32'h1, wdt_clr);
			chk("gates", co[i], {sys_en, tb_en, sub_en, wdt_run});
			@(negedge clock_in);
			chk("clear pulse end", 32'h0, wdt_clr);
			rd(STATE_ADDR, r);
			chk("sleep state", 32'(cs[i]), r);
			rd(STAT_ADDR, r);
			chk("entry flags", 32'h1, r);
			rd(MODE_ADDR, r);
			chk("slow ready", 32'(i != 0), r[LRDY_BIT]);
			pulse(1);
			wait_sig(0, 1'b1, 400, n);
			rd(STATE_ADDR, r);
			chk("awake", 32'(ST_RUN), r);
			pulse(3);
			rd(STAT_ADDR, r);
			chk("flags cleared", 32'h0, r);
		end
	endtask

	// Crystal with fast wake on: deep sleep waits the full count, the others run on the subclock.
	task automatic t_fast_xtal;
		logic [31:0] r;
		int          n;
		for (int i = 0; i < 3; i++)
		begin
			wdt_en <= (i != 0);
			lvd_en <= 1'b0;
			wr(MODE_ADDR, mw(1, i == 2, 1, 3'h0, OSC_XTAL, 0));
			pulse(0);
			pulse(1);
			wait_sig(0, 1'b1, 400, n);
			if (i == 0)
				chk_rng("deep wake", 128 * XD - 6, 128 * XD + 40, n);
			else
			begin
				chk_rng("fast wake", 0, 2 * SD + 6, n);
				chk("on subclock", 32'h1, on_low);
				wait_sig(1, 1'b0, 300, n);
				chk_rng("crystal switch", 128 * XD - 60, 128 * XD + 10, n);
				rd(MODE_ADDR, r);
				chk("crystal ready", 32'h1, r[HRDY_BIT]);
			end
		end
	endtask

	// Internal oscillators ignore the fast wake bit and wake in their own counts.
	task automatic t_osc_times;
		osc_t os [2] = '{OSC_FAST, OSC_SLOW};
		int   lo [2] = '{15 * FD - 4, SD - 4};
		int   hi [2] = '{16 * FD + 8, 2 * SD + 8};
		int   n;
		wdt_en <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			wr(MODE_ADDR, mw(1, 0, 1, 3'h0, os[i], 0));
			repeat (4 * SD) @(posedge clock_in);
			pulse(0);
			pulse(1);
			wait_sig(0, 1'b1, 100, n);
			chk_rng("internal wake", lo[i], hi[i], n);
			chk("not on subclock", 32'h0, on_low);
		end
		wr(MODE_ADDR, mw(1, 0, 0, 3'h0, OSC_XTAL, 0));
		wait_hrdy();
	endtask

	// Slow mode entry and both ways back to full speed.
	task automatic t_slow;
		logic [31:0] back [2];
		logic [31:0] r;
		int          n;
		back[0] = mw(0, 0, 0, 3'h2, OSC_XTAL, 0);
		back[1] = mw(1, 0, 0, 3'h0, OSC_XTAL, 0);
		for (int i = 0; i < 2; i++)
		begin
			wr(MODE_ADDR, mw(0, 0, 0, SLOW_DIV_MAX - 3'(i), OSC_XTAL, 0));
			wait_sig(1, 1'b1, 60, n);
			rd(MODE_ADDR, r);
			chk("slow ready", 32'h1, r[LRDY_BIT]);
			wait_sig(2, 1'b0, 4, n);
			wr(MODE_ADDR, back[i]);
			wait_sig(2, 1'b1, 6, n);
			wait_hrdy();
			wait_sig(1, 1'b0, 20, n);
			chk("fast osc on", 32'h1, hosc_en);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset for five clocks, then every scenario.
	initial
	begin
		miscompares = 0;
		checks = 0;
		nrst_in = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{halt, wake, wdt_en, lvd_en, wdt_to, wdt_clr_cmd} = '0;
		repeat (5) @(posedge clock_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		t_reset();
		t_halt_modes();
		t_fast_xtal();
		t_osc_times();
		t_slow();
		give_verdict();
	end

endmodule
